//--- comparator_consts.vh
// constants for the analog comparator control block
// How it works
// R1: raw result is high while selected positive level exceeds selected negative level.
// R2: mux enable with converter off picks converter channel 0..7 as negative input.
// R3: bandgap select feeds fixed reference to the positive input instead of the pin.
// R4: power-off bit removes comparator power any time; zero restores it.
// R5: compare_result is the raw result after two-flop sync, lagging one to two cycles.
// R6: matching synchronized edge sets compare_event_flag whatever the interrupt enable.
// R7: interrupt requested only while flag, compare_irq_enable and global enable are set.
// R8: flag clears on vector entry or writing one; writing zero leaves it.
// R9: mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// R10: software clears compare_irq_enable before changing event_mode_select.
// R11: software clears compare_irq_enable before toggling comparator_power_off.
// R12: capture route enable drives timer capture input with compare_result, else nothing.
// R13: software sets the timer's own capture interrupt enable for timer capture interrupts.
// R14: buffer-off bits disable pin input buffer and force pin state reads to zero.
// R15: upper six bits of the buffer-disable register ignore writes and read zero.
// R16: software should disable buffers of analog-only comparator pins to save power.
// R17: converter_enable switches converter on and takes the multiplexer from the comparator.
// R18: edges found by comparing current and previous synchronized result each clock.
// R19: reset clears every writable control bit: powered, pins selected, no irq, no route.
`ifndef COMPARATOR_CONSTS_VH
`define COMPARATOR_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_CTRL_STATUS 8'h50
`define IDX_CONV_B 8'h7B
`define IDX_BUF_DIS 8'h7F
`define IDX_CONV_SEL 8'h80
`define IDX_IRQ_STATUS 8'h81
`define IDX_IRQ_CLEAR 8'h82
`define IDX_IRQ_ENABLE 8'h83
`define IDX_LSB 2
`define IDX_MSB 9
`define ADDR_HI_LSB 10
`define ADDR_MSB 31
`define ALIGN_MSB 1
`define ALIGN_LSB 0
`define ADDR_HI_ZERO 22'h000000
`define ALIGN_ZERO 2'h0
`define RD_PAD 24'h000000
`define SEL_ZERO 3'h0

// comparator_control_status bits
`define CS_POWER_OFF 7
`define CS_BANDGAP 6
`define CS_RESULT 5
`define CS_FLAG 4
`define CS_IRQ_EN 3
`define CS_ROUTE 2
`define CS_MODE_HI 1
`define CS_MODE_LO 0

// converter_control_b bits
`define CB_MUX_EN 6
`define CB_TRIG_HI 2
`define CB_TRIG_LO 0

// comparator_pin_buffer_disable bits
`define BD_NEG 1
`define BD_POS 0

// converter select register bits
`define SEL_CONV_EN 0
`define SEL_CH_HI 3
`define SEL_CH_LO 1

// interrupt status, clear and enable layout
`define IRQ_EVENT 0

// event modes
`define MODE_TOGGLE 2'h0
`define MODE_RESERVED 2'h1
`define MODE_FALL 2'h2
`define MODE_RISE 2'h3

// analog levels
`define LEVEL_W 10
`define CHANNELS 8
`define BANDGAP_LEVEL 10'h1C0

`define HTRANS_NONSEQ_BIT 1
`define DATA_W 32
`define ZERO_BYTE 8'h00
`define ZERO_WORD 32'h00000000

`endif

//--- sync_two_flop.v
// two-flop synchroniser for a single level
`timescale 1ns/1ps
module sync_two_flop (
    input wire clk_sys,
    input wire resetn,
    input wire din,
    output reg dout
);
    reg stage1;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

//--- analog_comparator_control.v
// analog comparator control with AHB-Lite register slave
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "comparator_consts.vh"
module analog_comparator_control (
    input wire clk_sys,
    input wire resetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire [9:0] positive_input_pin,
    input wire [9:0] negative_input_pin,
    input wire [79:0] converter_channel_pins,
    input wire pos_pin_digital,
    input wire neg_pin_digital,
    input wire global_irq_enable,
    input wire irq_vector_ack,
    output reg comparator_power_off,
    output reg bandgap_positive_select,
    output reg converter_enable,
    output reg pos_pin_buffer_off,
    output reg neg_pin_buffer_off,
    output reg pos_pin_state,
    output reg neg_pin_state,
    output reg capture_trigger,
    output reg compare_irq
);
    // stored register fields
    reg compare_event_flag;
    reg compare_irq_enable;
    reg capture_route_enable;
    reg [1:0] event_mode_select;
    reg mux_negative_select_enable;
    reg [2:0] trigger_select;
    reg [2:0] channel_select;
    reg result_prev;
    reg wr_pend;
    reg rd_pend;
    reg [7:0] acc_idx;
    reg acc_ok;
    reg [9:0] pos_level;
    reg [9:0] neg_level;
    reg raw_result;
    reg event_hit;
    reg [7:0] rd_byte;
    reg next_flag;

    // decode nets and write strobes
    wire compare_result;
    wire addr_phase;
    wire addr_ok;
    wire [7:0] wbyte;
    wire wr_ctrl;
    wire wr_clear;
    wire flag_clear;
    wire wr_conv_b;
    wire wr_buf_dis;
    wire wr_conv_sel;
    wire wr_irq_en;

    // positive input mux
    always @* begin
        if (bandgap_positive_select) begin
            pos_level = `BANDGAP_LEVEL; // R3
        end else begin
            pos_level = positive_input_pin;
        end
    end

    // negative input mux; the converter owns the multiplexer while enabled
    always @* begin
        if (mux_negative_select_enable && !converter_enable) begin
            neg_level = converter_channel_pins[channel_select * `LEVEL_W +: `LEVEL_W]; // R2 R17
        end else begin
            neg_level = negative_input_pin;
        end
    end

    // analog decision; an unpowered comparator gives a low result
    always @* begin
        if (comparator_power_off) begin
            raw_result = 1'b0; // R4
        end else begin
            raw_result = (pos_level > neg_level); // R1
        end
    end

    sync_two_flop i_sync_two_flop (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din(raw_result),
        .dout(compare_result) // R5
    );

    // edge classification of the synchronized result
    always @* begin
        case (event_mode_select)
            `MODE_TOGGLE: event_hit = compare_result ^ result_prev; // R9 R18
            `MODE_FALL: event_hit = result_prev & ~compare_result; // R9
            `MODE_RISE: event_hit = compare_result & ~result_prev; // R9
            default: event_hit = 1'b0;
        endcase
    end

    // bus decode
    assign addr_phase = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
    assign addr_ok = (haddr[`ADDR_MSB:`ADDR_HI_LSB] == `ADDR_HI_ZERO)
        && (haddr[`ALIGN_MSB:`ALIGN_LSB] == `ALIGN_ZERO);
    assign wbyte = hwdata[7:0];
    assign wr_ctrl = wr_pend & acc_ok & (acc_idx == `IDX_CTRL_STATUS);
    assign wr_clear = wr_pend & acc_ok & (acc_idx == `IDX_IRQ_CLEAR);
    assign flag_clear = irq_vector_ack // R8
        | (wr_ctrl & wbyte[`CS_FLAG]) // R8
        | (wr_clear & wbyte[`IRQ_EVENT]);

    // a new event wins over a clear in the same cycle
    always @* begin
        next_flag = compare_event_flag;
        if (flag_clear) begin
            next_flag = 1'b0;
        end
        if (event_hit) begin
            next_flag = 1'b1; // R6
        end
    end

    // read mux
    always @* begin
        rd_byte = `ZERO_BYTE;
        case (acc_idx)
            `IDX_CTRL_STATUS: begin
                rd_byte[`CS_POWER_OFF] = comparator_power_off;
                rd_byte[`CS_BANDGAP] = bandgap_positive_select;
                rd_byte[`CS_RESULT] = compare_result; // R5
                rd_byte[`CS_FLAG] = compare_event_flag;
                rd_byte[`CS_IRQ_EN] = compare_irq_enable;
                rd_byte[`CS_ROUTE] = capture_route_enable;
                rd_byte[`CS_MODE_HI:`CS_MODE_LO] = event_mode_select;
            end
            `IDX_CONV_B: begin
                rd_byte[`CB_MUX_EN] = mux_negative_select_enable;
                rd_byte[`CB_TRIG_HI:`CB_TRIG_LO] = trigger_select;
            end
            `IDX_BUF_DIS: begin
                rd_byte[`BD_NEG] = neg_pin_buffer_off; // R15
                rd_byte[`BD_POS] = pos_pin_buffer_off;
            end
            `IDX_CONV_SEL: begin
                rd_byte[`SEL_CONV_EN] = converter_enable;
                rd_byte[`SEL_CH_HI:`SEL_CH_LO] = channel_select;
            end
            `IDX_IRQ_STATUS: begin
                rd_byte[`IRQ_EVENT] = compare_event_flag;
            end
            `IDX_IRQ_ENABLE: begin
                rd_byte[`IRQ_EVENT] = compare_irq_enable;
            end
            default: rd_byte = `ZERO_BYTE;
        endcase
        if (!acc_ok) begin
            rd_byte = `ZERO_BYTE;
        end
    end

    // AHB-Lite slave: writes take no wait state, reads take one
    always @(posedge clk_sys) begin
        if (!resetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            acc_idx <= `ZERO_BYTE;
            acc_ok <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= `ZERO_WORD;
        end else begin
            hresp <= 1'b0;
            // second cycle of a read: present data and end the wait state
            if (rd_pend) begin
                hrdata <= {`RD_PAD, rd_byte};
                hreadyout <= 1'b1;
                rd_pend <= 1'b0;
            end else if (addr_phase) begin
                // a read holds hready low for exactly one cycle
                acc_idx <= haddr[`IDX_MSB:`IDX_LSB];
                acc_ok <= addr_ok;
                wr_pend <= hwrite;
                rd_pend <= ~hwrite;
                hreadyout <= hwrite;
            end else begin
                wr_pend <= 1'b0;
            end
        end
    end

    // data-phase write strobes per register
    assign wr_conv_b = wr_pend & acc_ok & (acc_idx == `IDX_CONV_B);
    assign wr_buf_dis = wr_pend & acc_ok & (acc_idx == `IDX_BUF_DIS);
    assign wr_conv_sel = wr_pend & acc_ok & (acc_idx == `IDX_CONV_SEL);
    assign wr_irq_en = wr_pend & acc_ok & (acc_idx == `IDX_IRQ_ENABLE);

    // writable bits of comparator_control_status; result, flag and interrupt enable live elsewhere
    always @(posedge clk_sys) begin
        if (!resetn) begin
            comparator_power_off <= 1'b0; // R19
            bandgap_positive_select <= 1'b0;
            capture_route_enable <= 1'b0;
            event_mode_select <= `MODE_TOGGLE;
        end else if (wr_ctrl) begin
            comparator_power_off <= wbyte[`CS_POWER_OFF]; // R4
            bandgap_positive_select <= wbyte[`CS_BANDGAP]; // R3
            capture_route_enable <= wbyte[`CS_ROUTE]; // R12
            event_mode_select <= wbyte[`CS_MODE_HI:`CS_MODE_LO]; // R9
        end
    end

    // the interrupt enable is reachable through two register views
    always @(posedge clk_sys) begin
        if (!resetn) begin
            compare_irq_enable <= 1'b0;
        end else if (wr_ctrl) begin
            compare_irq_enable <= wbyte[`CS_IRQ_EN];
        end else if (wr_irq_en) begin
            compare_irq_enable <= wbyte[`IRQ_EVENT];
        end
    end

    // converter_control_b: multiplexer enable and plain trigger storage
    always @(posedge clk_sys) begin
        if (!resetn) begin
            mux_negative_select_enable <= 1'b0;
            trigger_select <= `SEL_ZERO;
        end else if (wr_conv_b) begin
            mux_negative_select_enable <= wbyte[`CB_MUX_EN]; // R2
            trigger_select <= wbyte[`CB_TRIG_HI:`CB_TRIG_LO];
        end
    end

    // pin buffer disable; the upper bits have no storage
    always @(posedge clk_sys) begin
        if (!resetn) begin
            neg_pin_buffer_off <= 1'b0;
            pos_pin_buffer_off <= 1'b0;
        end else if (wr_buf_dis) begin
            neg_pin_buffer_off <= wbyte[`BD_NEG]; // R14 R15
            pos_pin_buffer_off <= wbyte[`BD_POS];
        end
    end

    // converter on bit and channel select
    always @(posedge clk_sys) begin
        if (!resetn) begin
            converter_enable <= 1'b0;
            channel_select <= `SEL_ZERO;
        end else if (wr_conv_sel) begin
            converter_enable <= wbyte[`SEL_CONV_EN]; // R17
            channel_select <= wbyte[`SEL_CH_HI:`SEL_CH_LO];
        end
    end

    // synchronized result history and sticky event flag
    always @(posedge clk_sys) begin
        if (!resetn) begin
            result_prev <= 1'b0;
            compare_event_flag <= 1'b0;
        end else begin
            result_prev <= compare_result; // R18
            compare_event_flag <= next_flag; // R6 R8
        end
    end

    // level interrupt rises in the same cycle as the flag
    always @(posedge clk_sys) begin
        if (!resetn) begin
            compare_irq <= 1'b0;
        end else begin
            compare_irq <= next_flag & compare_irq_enable & global_irq_enable; // R7
        end
    end

    // capture route to the timer front end
    always @(posedge clk_sys) begin
        if (!resetn) begin
            capture_trigger <= 1'b0;
        end else begin
            capture_trigger <= capture_route_enable & compare_result; // R12
        end
    end

    // digital pin states, forced low while their buffers are off
    always @(posedge clk_sys) begin
        if (!resetn) begin
            pos_pin_state <= 1'b0;
            neg_pin_state <= 1'b0;
        end else begin
            pos_pin_state <= pos_pin_digital & ~pos_pin_buffer_off; // R14
            neg_pin_state <= neg_pin_digital & ~neg_pin_buffer_off; // R14
        end
    end
endmodule

//--- comparator_checks_assertions.sv
// port checker for the comparator control block
`timescale 1ns/1ps
module comparator_checks (
    input wire clk_sys,
    input wire resetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire global_irq_enable,
    input wire comparator_power_off,
    input wire pos_pin_buffer_off,
    input wire neg_pin_buffer_off,
    input wire pos_pin_state,
    input wire neg_pin_state,
    input wire capture_trigger,
    input wire compare_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    bus_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout)
        else $error("read without wait state");
    wait_one_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");
    pos_buf_a: assert property (pos_pin_buffer_off && $past(pos_pin_buffer_off) |-> !pos_pin_state)
        else $error("positive pin state not masked");
    neg_buf_a: assert property (neg_pin_buffer_off && $past(neg_pin_buffer_off) |-> !neg_pin_state)
        else $error("negative pin state not masked");
    irq_gate_a: assert property (compare_irq |-> $past(global_irq_enable))
        else $error("interrupt without global enable");
    power_quiet_a: assert property (comparator_power_off [*4] |=> !capture_trigger)
        else $error("capture trigger while powered off");
    reset_clear_a: assert property ($rose(resetn) |-> !comparator_power_off && !compare_irq && !capture_trigger)
        else $error("outputs not cleared by reset");
endmodule
bind analog_comparator_control comparator_checks i_comparator_checks (.clk_sys, .resetn,
    .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .global_irq_enable,
    .comparator_power_off, .pos_pin_buffer_off, .neg_pin_buffer_off, .pos_pin_state,
    .neg_pin_state, .capture_trigger, .compare_irq);

//--- analog_front_model.sv
// analog pin levels, digital pads and timer capture front end
`timescale 1ns/1ps
module analog_front_model (
    input wire clk_sys,
    input wire capture_trigger,
    output reg [9:0] positive_input_pin,
    output reg [9:0] negative_input_pin,
    output reg [79:0] converter_channel_pins,
    output reg pos_pin_digital,
    output reg neg_pin_digital,
    output reg [15:0] captures
);
    reg timer_capture_irq_enable = 1'b1;
    reg last_trig = 1'b0;
    integer i;
    initial begin
        positive_input_pin = 10'h000;
        negative_input_pin = 10'h3FF;
        pos_pin_digital = 1'b1;
        neg_pin_digital = 1'b1;
        captures = 16'h0000;
        for (i = 0; i < 8; i = i + 1) begin
            converter_channel_pins[10*i +: 10] = 10'(i * 64 + 32);
        end
    end
    // rising capture edges counted only with the timer capture enable set
    always @(posedge clk_sys) begin
        last_trig <= capture_trigger;
        if (capture_trigger && !last_trig && timer_capture_irq_enable) begin
            captures <= captures + 16'h0001;
        end
    end
    task drive(input [9:0] p, input [9:0] n);
        begin
            @(posedge clk_sys);
            positive_input_pin <= p;
            negative_input_pin <= n;
        end
    endtask
endmodule

//--- test_analog_comparator_control.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "comparator_consts.vh"
module test_analog_comparator_control;
    reg clk_sys = 1'b0;
    reg resetn = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h00000000;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h00000000;
    reg global_irq_enable = 1'b0;
    reg irq_vector_ack = 1'b0;
    wire hreadyout, hresp, pos_pin_digital, neg_pin_digital;
    wire comparator_power_off, bandgap_positive_select, converter_enable;
    wire pos_pin_buffer_off, neg_pin_buffer_off, pos_pin_state, neg_pin_state;
    wire capture_trigger, compare_irq;
    wire [31:0] hrdata;
    wire [9:0] positive_input_pin, negative_input_pin;
    wire [79:0] converter_channel_pins;
    wire [15:0] captures;
    integer n_errors = 0;
    integer total_checks = 0;
    integer cycles = 0;
    integer k;
    reg [31:0] rd;
    analog_comparator_control i_analog_comparator_control (.clk_sys, .resetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .positive_input_pin, .negative_input_pin, .converter_channel_pins,
        .pos_pin_digital, .neg_pin_digital, .global_irq_enable, .irq_vector_ack,
        .comparator_power_off, .bandgap_positive_select, .converter_enable,
        .pos_pin_buffer_off, .neg_pin_buffer_off, .pos_pin_state, .neg_pin_state,
        .capture_trigger, .compare_irq);
    analog_front_model i_analog_front_model (.clk_sys, .capture_trigger, .positive_input_pin,
        .negative_input_pin, .converter_channel_pins, .pos_pin_digital, .neg_pin_digital,
        .captures);
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    task stop_test;
        begin
            $display("checks %0d errors %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            stop_test;
        end
    end
    task chk(input [8*8:1] name, input [31:0] exp, input [31:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    // hready is judged from its settled level at the falling edge before the sampling edge
    task wait_rdy;
        reg r;
        begin
            r = 1'b0;
            while (r !== 1'b1) begin
                @(negedge clk_sys);
                r = hreadyout;
                rd = hrdata;
                @(posedge clk_sys);
            end
        end
    endtask
    task xfer(input wr, input [7:0] idx, input [31:0] wd);
        begin
            @(posedge clk_sys);
            hsel <= 1'b1;
            haddr <= {22'h000000, idx, 2'h0};
            htrans <= 2'h2;
            hwrite <= wr;
            wait_rdy;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            wait_rdy;
        end
    endtask
    task rchk(input [7:0] idx, input [31:0] exp);
        begin
            xfer(1'b0, idx, 32'h00000000);
            chk("register", exp, rd);
        end
    endtask
    task wt;
        repeat (4) @(posedge clk_sys);
    endtask
    task lv(input [9:0] p, input [9:0] n);
        begin
            i_analog_front_model.drive(p, n);
            wt;
        end
    endtask
    task res(input e);
        begin
            xfer(1'b0, `IDX_CTRL_STATUS, 32'h00000000);
            chk("result", {31'h0, e}, {31'h0, rd[5]});
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        rchk(`IDX_CTRL_STATUS, 32'h00000000);
        rchk(`IDX_CONV_B, 32'h00000000);
        xfer(1'b1, `IDX_BUF_DIS, 32'h000000FF);
        rchk(`IDX_BUF_DIS, 32'h00000003);
        @(negedge clk_sys);
        chk("pins", 32'h0, {30'h0, pos_pin_state, neg_pin_state});
        xfer(1'b1, `IDX_BUF_DIS, 32'h00000000);
        wt;
        chk("pins", 32'h3, {30'h0, pos_pin_state, neg_pin_state});
        i_analog_front_model.pos_pin_digital <= 1'b0;
        wt;
        chk("pins", 32'h1, {30'h0, pos_pin_state, neg_pin_state});
        i_analog_front_model.pos_pin_digital <= 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            xfer(1'b1, `IDX_CTRL_STATUS, k | 32'h10);
            lv(10'h300, 10'h100);
            rchk(`IDX_IRQ_STATUS, {31'h0, k == 0 || k == 3});
            xfer(1'b1, `IDX_CTRL_STATUS, k | 32'h10);
            rchk(`IDX_IRQ_STATUS, 32'h0);
            lv(10'h100, 10'h300);
            rchk(`IDX_IRQ_STATUS, {31'h0, k == 0 || k == 2});
        end
        xfer(1'b1, `IDX_CTRL_STATUS, 32'h1B);
        global_irq_enable <= 1'b1;
        lv(10'h300, 10'h100);
        rchk(`IDX_IRQ_ENABLE, 32'h1);
        chk("irq", 32'h1, {31'h0, compare_irq});
        xfer(1'b1, `IDX_CTRL_STATUS, 32'h0B);
        rchk(`IDX_IRQ_STATUS, 32'h1);
        global_irq_enable <= 1'b0;
        wt;
        chk("irq", 32'h0, {31'h0, compare_irq});
        global_irq_enable <= 1'b1;
        irq_vector_ack <= 1'b1;
        @(posedge clk_sys);
        irq_vector_ack <= 1'b0;
        wt;
        chk("irq", 32'h0, {31'h0, compare_irq});
        lv(10'h100, 10'h300);
        lv(10'h300, 10'h100);
        chk("irq", 32'h1, {31'h0, compare_irq});
        xfer(1'b1, `IDX_IRQ_ENABLE, 32'h0);
        wt;
        chk("irq", 32'h0, {31'h0, compare_irq});
        rchk(`IDX_IRQ_STATUS, 32'h1);
        xfer(1'b1, `IDX_IRQ_CLEAR, 32'h1);
        rchk(`IDX_IRQ_STATUS, 32'h0);
        xfer(1'b1, `IDX_CTRL_STATUS, 32'h50);
        @(negedge clk_sys);
        chk("bandgap", 32'h1, {31'h0, bandgap_positive_select});
        lv(10'h000, `BANDGAP_LEVEL - 10'h001);
        res(1'b1);
        lv(10'h000, `BANDGAP_LEVEL + 10'h001);
        res(1'b0);
        xfer(1'b1, `IDX_CTRL_STATUS, 32'h10);
        xfer(1'b1, `IDX_CONV_B, 32'hFF);
        rchk(`IDX_CONV_B, 32'h00000047);
        for (k = 0; k < 8; k = k + 1) begin
            xfer(1'b1, `IDX_CONV_SEL, k * 2);
            lv(10'(k * 64 + 16), 10'h3FF);
            res(1'b0);
            lv(10'(k * 64 + 64), 10'h3FF);
            res(1'b1);
        end
        xfer(1'b1, `IDX_CONV_SEL, 32'h1);
        rchk(`IDX_CONV_SEL, 32'h00000001);
        chk("convon", 32'h1, {31'h0, converter_enable});
        wt;
        res(1'b0);
        xfer(1'b1, `IDX_CONV_SEL, 32'h0);
        xfer(1'b1, `IDX_CONV_B, 32'h0);
        lv(10'h300, 10'h100);
        chk("capture", 32'h0, {31'h0, capture_trigger});
        xfer(1'b1, `IDX_CTRL_STATUS, 32'h04);
        wt;
        chk("capture", 32'h1, {31'h0, capture_trigger});
        chk("captures", 32'h1, {16'h0, captures});
        xfer(1'b1, `IDX_CTRL_STATUS, 32'h84);
        wt;
        res(1'b0);
        chk("capture", 32'h0, {31'h0, capture_trigger});
        chk("power", 32'h1, {31'h0, comparator_power_off});
        xfer(1'b1, `IDX_CTRL_STATUS, 32'h04);
        wt;
        res(1'b1);
        xfer(1'b1, 8'hA0, 32'h000000FF);
        rchk(8'hA0, 32'h00000000);
        stop_test;
    end
endmodule
